/* File: core/mtm_pkg.sv */
// Shared constants of the modulo timer control block.
// Assumes an 8-bit register port with 2 address bits.
package mtm_pkg;

    // Data and address widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 2;

    // Register indices on the plain register port
    localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_CLOCK_CONFIG   = 2'h1;
    localparam logic [1:0] ADDR_COUNT_VALUE    = 2'h2;
    localparam logic [1:0] ADDR_WRAP_LIMIT     = 2'h3;

    // Status/control field positions
    localparam int SC_OVERFLOW_BIT = 7;
    localparam int SC_IRQ_EN_BIT   = 6;
    localparam int SC_CNT_RST_BIT  = 5;
    localparam int SC_HALT_BIT     = 4;

    // Clock configuration field positions
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_DIV_LSB = 0;

    // Reset values
    localparam logic       HALT_RST   = 1'b1;
    localparam logic       IRQ_EN_RST = 1'b0;
    localparam logic [1:0] SRC_RST    = 2'h0;
    localparam logic [3:0] DIV_RST    = 4'h0;
    localparam logic [7:0] COUNT_RST  = 8'h00;
    localparam logic [7:0] LIMIT_RST  = 8'h00;

    // Counter wrap constants
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_TOP  = 8'hFF;

    // Divider ceiling: codes above this divide by 256
    localparam logic [3:0] DIV_MAX_CODE = 4'h8;

    // Prescaler input selection
    typedef enum logic [1:0] {
        MTM_SRC_BUS  = 2'h0,
        MTM_SRC_FIX  = 2'h1,
        MTM_SRC_FALL = 2'h2,
        MTM_SRC_RISE = 2'h3
    } mtm_src_t;

endpackage

/* File: core/mtm_prescaler.sv */
// Prescaler: divides source pulses by 2^n, n up to eight.
// Assumes source pulses are one bus cycle wide.
`timescale 1ns/1ps
`default_nettype none
module mtm_prescaler
    import mtm_pkg::*;
#(
    parameter int PRE_W = 8  // Prescaler stages
)
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    mtm_tick_if.pre   tk
);
    logic [PRE_W-1:0] pre_q;   // Free-running source pulse count
    logic [3:0]       stages;  // Clamped divider code
    logic [PRE_W-1:0] mask;    // Low bits that must be all ones

    // Codes above eight clamp to divide-by-256
    assign stages = (tk.divider_select > DIV_MAX_CODE) ? DIV_MAX_CODE : tk.divider_select;
    assign mask   = ~({PRE_W{1'b1}} << stages);
    // Tick is one bus cycle wide and only on a source pulse
    assign tk.tick = tk.src_pulse & ((pre_q & mask) == mask);

    // Never cleared on a code change, so counting carries on
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pre_q <= '0;
        else if (tk.src_pulse)
            pre_q <= pre_q + 1'b1;
    end

    property p_tick_needs_src;
        @(posedge clk_sys) disable iff (!rst_n)
        tk.tick |-> tk.src_pulse;
    endproperty
    a_tick_needs_src: assert property (p_tick_needs_src) else $error("tick without source");

    property p_div_max;
        @(posedge clk_sys) disable iff (!rst_n)
        (tk.tick && tk.divider_select >= DIV_MAX_CODE) |-> (pre_q == {PRE_W{1'b1}});
    endproperty
    a_div_max: assert property (p_div_max) else $error("high code not div 256");
endmodule
`default_nettype wire

/* File: core/mtm_src_sel.sv */
// Source selector: turns the chosen clock source into bus-clock pulses.
// Assumes the external pin is asynchronous and below a quarter bus rate.
`timescale 1ns/1ps
`default_nettype none
module mtm_src_sel
    import mtm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic fixed_freq_clock,
    input  wire logic external_count_pin,
    mtm_tick_if.src   tk
);
    logic ext_meta_q;  // First synchroniser stage
    logic ext_sync_q;  // Second synchroniser stage
    logic ext_prev_q;  // Delayed copy for edge detection
    logic fix_prev_q;  // Delayed fixed clock

    wire ext_rise = ext_sync_q & ~ext_prev_q;
    wire ext_fall = ~ext_sync_q & ext_prev_q;
    wire fix_rise = fixed_freq_clock & ~fix_prev_q;

    // Pin passes two flops before any edge logic sees it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
            fix_prev_q <= 1'b0;
        end
        else
        begin
            ext_meta_q <= external_count_pin;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
            fix_prev_q <= fixed_freq_clock;
        end
    end

    // Source multiplexer; bus source pulses every cycle
    always_comb
    begin
        case (tk.source_select)
            MTM_SRC_BUS:  tk.src_pulse = 1'b1;
            MTM_SRC_FIX:  tk.src_pulse = fix_rise;
            MTM_SRC_FALL: tk.src_pulse = ext_fall;
            MTM_SRC_RISE: tk.src_pulse = ext_rise;
            default:      tk.src_pulse = 1'b1;
        endcase
    end

    property p_rise_src;
        @(posedge clk_sys) disable iff (!rst_n)
        (tk.source_select == MTM_SRC_RISE && tk.src_pulse) |-> $rose(ext_sync_q);
    endproperty
    a_rise_src: assert property (p_rise_src) else $error("rise pulse without edge");

    property p_fall_src;
        @(posedge clk_sys) disable iff (!rst_n)
        (tk.source_select == MTM_SRC_FALL && tk.src_pulse) |-> $fell(ext_sync_q);
    endproperty
    a_fall_src: assert property (p_fall_src) else $error("fall pulse without edge");
endmodule
`default_nettype wire

/* File: core/mtm_tick_if.sv */
// Carrier between the timer core and its clock front end.
// Assumes all members live in the single bus clock domain.
`timescale 1ns/1ps
`default_nettype none
interface mtm_tick_if;
    import mtm_pkg::*;
    mtm_src_t   source_select;  // Chosen prescaler input
    logic [3:0] divider_select; // Divide-by-2^n code
    logic       src_pulse;      // One enable per source event
    logic       tick;           // Prescaled counting enable

    modport ctl (output source_select, output divider_select, input tick);
    modport src (input source_select, output src_pulse);
    modport pre (input divider_select, input src_pulse, output tick);
endinterface
`default_nettype wire

/* File: core/mtm_timer.sv */
// Modulo timer: control registers, overflow flag, 8-bit counter.
// Assumes a one-cycle strobe register port; read data one cycle later.
// Notes on behaviour
// - Overflow flag sets on wrap to zero
// - Flag clears by read then write zero
// - Counter reset or limit write clears flag
// - Enable gates flag onto interrupt request
// - Counter reset bit zeroes count, reads zero
// - Halt bit freezes count; reset sets it
// - Unused control and config bits read zero
// - Source select picks bus, fixed, pin edges
// - Source change never clears the counter
// - Reset clears source select to bus
// - Divider code gives 2^n, clamps at 256
// - Divider change never clears the counter
// - Reset clears divider select to zero, divide by one
// - Four 8-bit registers are provided
// - Count up to limit, wrap, continue
// - Overflow between clear steps cancels clear
// - Zero limit means free-running counter
// - External pin synchronised before edge detection
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mtm_timer
    import mtm_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              fixed_freq_clock,
    input  wire logic              external_count_pin,
    output logic                   timer_irq
);
    // Clock front end carrier
    mtm_tick_if tk ();

    // Control state
    logic        overflow_flag_q;        // Sticky overflow
    logic        overflow_flag_d;
    logic        clear_armed_q;          // First clear step seen
    logic        clear_armed_d;
    logic        overflow_irq_enable_q;  // Interrupt enable
    logic        counter_halt_q;         // Counter stopped
    mtm_src_t    source_select_q;        // Prescaler input
    logic [3:0]  divider_select_q;       // Divide code
    logic [7:0]  count_q;                // Counter value
    logic [7:0]  count_d;
    logic [7:0]  wrap_limit_value_q;     // Modulo limit
    logic [7:0]  rdata_q;                // Registered read data
    logic [7:0]  rd_mux;                 // Selected read word

    // Address decode
    wire sel_sc  = (reg_addr == ADDR_STATUS_CONTROL);
    wire sel_cfg = (reg_addr == ADDR_CLOCK_CONFIG);
    wire sel_lim = (reg_addr == ADDR_WRAP_LIMIT);
    wire sc_wr   = reg_wr & sel_sc;
    wire sc_rd   = reg_rd & sel_sc;
    wire cfg_wr  = reg_wr & sel_cfg;
    wire lim_wr  = reg_wr & sel_lim;

    // Counter control terms
    wire cnt_reset = (sc_wr & reg_wdata[SC_CNT_RST_BIT]) | lim_wr;
    wire run_tick  = tk.tick & ~counter_halt_q;
    // Zero limit wraps at the top of the range
    wire at_top    = (wrap_limit_value_q == COUNT_ZERO) ? (count_q == COUNT_TOP)
                                                        : (count_q == wrap_limit_value_q);
    wire ov_evt    = run_tick & at_top;
    wire flag_wr0  = sc_wr & ~reg_wdata[SC_OVERFLOW_BIT] & clear_armed_q;

    // Front end wiring
    assign tk.source_select  = source_select_q;
    assign tk.divider_select = divider_select_q;

    mtm_src_sel u_src (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .fixed_freq_clock   (fixed_freq_clock),
        .external_count_pin (external_count_pin),
        .tk                 (tk.src)
    );

    mtm_prescaler #(
        .PRE_W (8)
    ) u_pre (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tk      (tk.pre)
    );

    // Next count: software reset wins, else step or wrap
    always_comb
    begin
        if (cnt_reset)
            count_d = COUNT_ZERO;
        else if (run_tick)
            count_d = at_top ? COUNT_ZERO : count_q + 8'h01;
        else
            count_d = count_q;
    end

    // Flag: a new overflow wins over any clear in the same cycle
    always_comb
    begin
        if (ov_evt)
            overflow_flag_d = 1'b1;
        else if (cnt_reset | flag_wr0)
            overflow_flag_d = 1'b0;
        else
            overflow_flag_d = overflow_flag_q;
    end

    // Clear sequence: armed by a read with flag set, dropped by overflow
    always_comb
    begin
        if (ov_evt)
            clear_armed_d = 1'b0;
        else if (sc_rd & overflow_flag_q)
            clear_armed_d = 1'b1;
        else if (sc_wr | cnt_reset)
            clear_armed_d = 1'b0;
        else
            clear_armed_d = clear_armed_q;
    end

    // Counter and flag state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q         <= COUNT_RST;
            overflow_flag_q <= 1'b0;
            clear_armed_q   <= 1'b0;
        end
        else
        begin
            count_q         <= count_d;
            overflow_flag_q <= overflow_flag_d;
            clear_armed_q   <= clear_armed_d;
        end
    end

    // Status/control writable bits; halt starts set
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_irq_enable_q <= IRQ_EN_RST;
            counter_halt_q        <= HALT_RST;
        end
        else if (sc_wr)
        begin
            overflow_irq_enable_q <= reg_wdata[SC_IRQ_EN_BIT];
            counter_halt_q        <= reg_wdata[SC_HALT_BIT];
        end
    end

    // Clock configuration; no effect on the count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            source_select_q  <= MTM_SRC_BUS;
            divider_select_q <= DIV_RST;
        end
        else if (cfg_wr)
        begin
            source_select_q  <= mtm_src_t'(reg_wdata[CFG_SRC_LSB +: 2]);
            divider_select_q <= reg_wdata[CFG_DIV_LSB +: 4];
        end
    end

    // Modulo limit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            wrap_limit_value_q <= LIMIT_RST;
        else if (lim_wr)
            wrap_limit_value_q <= reg_wdata;
    end

    // Read word selection; reset bit and unused bits read zero
    always_comb
    begin
        case (reg_addr)
            ADDR_STATUS_CONTROL: rd_mux = {overflow_flag_q, overflow_irq_enable_q, 1'b0,
                                           counter_halt_q, 4'h0};
            ADDR_CLOCK_CONFIG:   rd_mux = {2'h0, source_select_q, divider_select_q};
            ADDR_COUNT_VALUE:    rd_mux = count_q;
            ADDR_WRAP_LIMIT:     rd_mux = wrap_limit_value_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    // Read data register, loaded on each read strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;
    // Level request; software must clear the flag before enabling
    assign timer_irq = overflow_flag_q & overflow_irq_enable_q;

    // Checks, all in the bus clock domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Two-step clear with one idle cycle between the steps
    sequence s_arm_read;
        sc_rd && overflow_flag_q && !ov_evt;
    endsequence

    sequence s_quiet;
        !ov_evt && !sc_wr && !cnt_reset;
    endsequence

    sequence s_clear_write;
        sc_wr && !reg_wdata[SC_OVERFLOW_BIT] && !ov_evt;
    endsequence

    property p_flag_sets;
        ov_evt |=> overflow_flag_q && count_q == COUNT_ZERO;
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("overflow not flagged");

    property p_two_step;
        s_arm_read ##1 s_quiet ##1 s_clear_write |=> !overflow_flag_q;
    endproperty
    a_two_step: assert property (p_two_step) else $error("two-step clear failed");

    property p_flag_fall_cause;
        $fell(overflow_flag_q) |-> $past(cnt_reset) || $past(flag_wr0);
    endproperty
    a_flag_fall_cause: assert property (p_flag_fall_cause) else $error("flag fell alone");

    property p_reset_bit;
        (cnt_reset && !ov_evt) |=> count_q == COUNT_ZERO && !overflow_flag_q;
    endproperty
    a_reset_bit: assert property (p_reset_bit) else $error("counter reset failed");

    property p_irq;
        timer_irq == (overflow_flag_q && overflow_irq_enable_q);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_halt_holds;
        (counter_halt_q && !cnt_reset) |=> $stable(count_q);
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("halted count moved");

    property p_unused_zero;
        sc_rd |=> reg_rdata[3:0] == 4'h0 && reg_rdata[SC_CNT_RST_BIT] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    property p_cfg_keeps_count;
        (cfg_wr && !cnt_reset && !ov_evt && count_q != COUNT_ZERO) |=> count_q != COUNT_ZERO;
    endproperty
    a_cfg_keeps_count: assert property (p_cfg_keeps_count) else $error("cfg cleared count");

    property p_free_run;
        (run_tick && wrap_limit_value_q == COUNT_ZERO && count_q == COUNT_TOP && !cnt_reset)
            |=> count_q == COUNT_ZERO && overflow_flag_q;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free-run wrap wrong");

    property p_abandon;
        (clear_armed_q && ov_evt) |=> !clear_armed_q && overflow_flag_q;
    endproperty
    a_abandon: assert property (p_abandon) else $error("clear not abandoned");

    // Limit write zeroes count and flag, even while halted
    property p_limit_clears;
        (lim_wr && !ov_evt) |=> count_q == COUNT_ZERO && !overflow_flag_q;
    endproperty
    a_limit_clears: assert property (p_limit_clears) else $error("limit write kept state");

    // Below the limit each counting edge adds exactly one
    property p_step;
        (run_tick && !at_top && !cnt_reset) |=> count_q == $past(count_q) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count step wrong");

    // Without a prescaled tick or a counter reset the count never moves
    property p_idle_holds;
        (!run_tick && !cnt_reset) |=> $stable(count_q);
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("count moved without tick");

    // Flag rises only through a wrap
    property p_flag_rise_cause;
        $rose(overflow_flag_q) |-> $past(ov_evt);
    endproperty
    a_flag_rise_cause: assert property (p_flag_rise_cause) else $error("flag rose alone");

    // Count read returns the value seen at the strobe
    property p_rd_count;
        (reg_rd && reg_addr == ADDR_COUNT_VALUE) |=> reg_rdata == $past(count_q);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the modulo timer control block.
// Assumes the register port takes one-cycle strobes and answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mtm_pkg::*;

    logic              clk_sys            = 1'b0;  // 20 MHz bus clock
    logic              rst_n              = 1'b0;  // Active low reset
    logic [ADDR_W-1:0] reg_addr           = 2'h0;  // Register index
    logic [DATA_W-1:0] reg_wdata          = 8'h00; // Write data
    logic              reg_wr             = 1'b0;  // Write strobe
    logic              reg_rd             = 1'b0;  // Read strobe
    logic [DATA_W-1:0] reg_rdata;                  // Read data
    logic              fixed_freq_clock   = 1'b0;  // Fixed clock, toggled by hand
    logic              external_count_pin = 1'b0;  // Pin, toggled well below clk/4
    logic              timer_irq;                  // Interrupt level
    int                n_mismatch         = 0;     // Mismatches seen
    int                tests_run          = 0;     // Comparisons made

    // Free-running bus clock, 50 ns period
    always #25 clk_sys = ~clk_sys;

    mtm_timer mtm_timer_i (
        .clk_sys            (clk_sys),
        .rst_n              (rst_n),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .fixed_freq_clock   (fixed_freq_clock),
        .external_count_pin (external_count_pin),
        .timer_irq          (timer_irq)
    );

    // Single comparison point, case inequality so unknowns fail
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data sampled in the following cycle only
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(v, exp);
    endtask

    // Reset values of all four registers
    task automatic t_reset();
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
        rd_chk(ADDR_CLOCK_CONFIG, 8'h00);
        rd_chk(ADDR_COUNT_VALUE, 8'h00);
        rd_chk(ADDR_WRAP_LIMIT, 8'h00);
        check({7'h00, timer_irq}, 8'h00);
    endtask

    // Unused bits, write-only reset bit, read-only count
    task automatic t_unused();
        wr(ADDR_CLOCK_CONFIG, 8'hFF);
        rd_chk(ADDR_CLOCK_CONFIG, 8'h3F);
        wr(ADDR_STATUS_CONTROL, 8'h3F);
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
        wr(ADDR_COUNT_VALUE, 8'h55);
        rd_chk(ADDR_COUNT_VALUE, 8'h00);
        wr(ADDR_WRAP_LIMIT, 8'hA5);
        rd_chk(ADDR_WRAP_LIMIT, 8'hA5);
        wr(ADDR_CLOCK_CONFIG, 8'h00);
        wr(ADDR_WRAP_LIMIT, 8'h00);
    endtask

    // Free-running wrap from the top, then a clear without the arming read
    task automatic t_free();
        logic [7:0] v;
        wr(ADDR_STATUS_CONTROL, 8'h00);
        cyc(200);
        wr(ADDR_STATUS_CONTROL, 8'h10);
        rd(ADDR_COUNT_VALUE, v);
        check({7'h00, (v >= 8'hC3) && (v <= 8'hD2)}, 8'h01);
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        cyc(70);
        // This write is not preceded by a read with the flag set
        wr(ADDR_STATUS_CONTROL, 8'h10);
        #1;
        check({7'h00, timer_irq}, 8'h00);
        rd_chk(ADDR_STATUS_CONTROL, 8'h90);
        rd(ADDR_COUNT_VALUE, v);
        check({7'h00, v < 8'h1E}, 8'h01);
        wr(ADDR_STATUS_CONTROL, 8'h10);
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
    endtask

    // Overflow between arming read and clearing write keeps the flag
    task automatic t_abort();
        wr(ADDR_WRAP_LIMIT, 8'h04);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        cyc(10);
        rd_chk(ADDR_STATUS_CONTROL, 8'h80);
        cyc(10);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        rd_chk(ADDR_STATUS_CONTROL, 8'h80);
        // Counter reset with halt stops and clears count and flag
        wr(ADDR_STATUS_CONTROL, 8'h30);
        rd_chk(ADDR_COUNT_VALUE, 8'h00);
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
        // Limit write while halted with flag set
        wr(ADDR_STATUS_CONTROL, 8'h00);
        cyc(12);
        wr(ADDR_STATUS_CONTROL, 8'h10);
        // Fourteen ticks on a period of five leave the count at four
        rd_chk(ADDR_COUNT_VALUE, 8'h04);
        wr(ADDR_WRAP_LIMIT, 8'h04);
        rd_chk(ADDR_COUNT_VALUE, 8'h00);
        rd_chk(ADDR_STATUS_CONTROL, 8'h10);
    endtask

    // Enable set only with the flag clear; flag then drives the request
    task automatic t_irq();
        wr(ADDR_STATUS_CONTROL, 8'h40);
        #1;
        check({7'h00, timer_irq}, 8'h00);
        cyc(10);
        wr(ADDR_STATUS_CONTROL, 8'h50);
        #1;
        check({7'h00, timer_irq}, 8'h01);
        rd_chk(ADDR_STATUS_CONTROL, 8'hD0);
        wr(ADDR_STATUS_CONTROL, 8'h50);
        #1;
        check({7'h00, timer_irq}, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h10);
    endtask

    // Rate for several divider codes, including one above the ceiling
    task automatic t_div();
        logic [3:0] codes [5];
        int         lens  [5];
        int         sh;
        int         e;
        logic [7:0] v;
        codes = '{4'h0, 4'h1, 4'h3, 4'h8, 4'hC};
        lens  = '{40, 80, 160, 2560, 2560};
        wr(ADDR_WRAP_LIMIT, 8'h00);
        for (int k = 0; k < 5; k++)
        begin
            sh = (codes[k] > 4'h8) ? 8 : int'(codes[k]);
            e  = (lens[k] + 2) >> sh;
            wr(ADDR_CLOCK_CONFIG, {4'h0, codes[k]});
            wr(ADDR_STATUS_CONTROL, 8'h20);
            cyc(lens[k]);
            wr(ADDR_STATUS_CONTROL, 8'h10);
            rd(ADDR_COUNT_VALUE, v);
            check({7'h00, (int'(v) >= e - 2) && (int'(v) <= e + 2)}, 8'h01);
        end
    endtask

    // Fixed clock and both pin edges; config changes keep the count
    task automatic t_src();
        wr(ADDR_CLOCK_CONFIG, 8'h10);
        wr(ADDR_STATUS_CONTROL, 8'h20);
        cyc(20);
        rd_chk(ADDR_COUNT_VALUE, 8'h00);
        cyc(1);
        for (int k = 0; k < 3; k++)
        begin
            fixed_freq_clock <= 1'b1;
            cyc(4);
            fixed_freq_clock <= 1'b0;
            cyc(4);
        end
        cyc(4);
        rd_chk(ADDR_COUNT_VALUE, 8'h03);
        wr(ADDR_CLOCK_CONFIG, 8'h13);
        rd_chk(ADDR_COUNT_VALUE, 8'h03);
        wr(ADDR_CLOCK_CONFIG, 8'h20);
        rd_chk(ADDR_COUNT_VALUE, 8'h03);
        cyc(1);
        external_count_pin <= 1'b1;
        cyc(10);
        rd_chk(ADDR_COUNT_VALUE, 8'h03);
        cyc(1);
        external_count_pin <= 1'b0;
        cyc(10);
        rd_chk(ADDR_COUNT_VALUE, 8'h04);
        wr(ADDR_CLOCK_CONFIG, 8'h30);
        external_count_pin <= 1'b1;
        cyc(10);
        rd_chk(ADDR_COUNT_VALUE, 8'h05);
        cyc(1);
        external_count_pin <= 1'b0;
        cyc(10);
        rd_chk(ADDR_COUNT_VALUE, 8'h05);
        wr(ADDR_STATUS_CONTROL, 8'h10);
    endtask

    // Verdict, reached from the main sequence or the watchdog
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_unused();
        t_free();
        t_abort();
        t_irq();
        t_div();
        t_src();
        summarize();
    end

    // Watchdog: run needs about 6000 cycles, allow far more
    initial
    begin
        #(20000 * 50);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
